// File: sim/cpu_bus_model.sv
// cpu bus model: drives opcode fetches and data cycles into the debug block
`timescale 1ns/1ps
`default_nettype none

module cpu_bus_model (
  input wire logic clk_in,
  input wire logic run_in,
  input wire logic rd_in,
  input wire logic [15:0] addr_in,
  output var dbg_regs_pkg::cpu_bus_t bus_out
);
  initial bus_out = '0;

  // idle cycles flip address and data so a stale cycle never looks like a real one
  always @(posedge clk_in)
  begin
    if (run_in)
    begin
      bus_out.valid <= 1'b1;
      bus_out.read <= rd_in;
      bus_out.opcode_fetch <= rd_in;
      bus_out.addr <= addr_in;
      bus_out.data <= addr_in[7:0];
    end
    else
    begin
      bus_out.valid <= 1'b0;
      bus_out.opcode_fetch <= 1'b0;
      bus_out.addr <= ~bus_out.addr;
      bus_out.data <= ~bus_out.data;
    end
  end
endmodule

`default_nettype wire

// File: sim/onchip_debug_trace_regs_bench.sv
// self-checking bench for the debug comparators, trace fifo and control registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end

module onchip_debug_trace_regs_bench;
  logic ref_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [3:0] reg_addr_in = 4'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic host_access_in = 1'b0;
  logic secure_in = 1'b0;
  dbg_regs_pkg::trig_cfg_t trig_cfg_in = '0;
  dbg_regs_pkg::cpu_bus_t cpu_bus_in;
  logic run = 1'b0;
  logic bus_rd = 1'b1;
  logic [15:0] bus_addr = 16'h0000;
  logic [7:0] reg_rdata_out;
  logic armed_out, cpu_break_out, break_tag_out, chip_reset_out;
  logic [3:0] fifo_count_out;
  logic rd_q = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] exp_v;
  logic [15:0] ta, tb, tp, ev;
  logic tag_seen;
  int brk_n;
  int brk_at;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;
  // row: [7] use comparator b, [6] cpu read, [5] break enable, [4] match expected, [3:0] direction bits
  logic [7:0] rows [6] = '{8'h70, 8'h64, 8'h7C, 8'hB1, 8'hA3, 8'h50};

  initial forever #25 ref_clk_in = ~ref_clk_in;

  onchip_debug_trace_regs u_dut (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .host_access_in(host_access_in),
    .secure_in(secure_in), .cpu_bus_in(cpu_bus_in), .trig_cfg_in(trig_cfg_in), .reg_rdata_out(reg_rdata_out),
    .armed_out(armed_out), .fifo_count_out(fifo_count_out), .cpu_break_out(cpu_break_out),
    .break_tag_out(break_tag_out), .chip_reset_out(chip_reset_out));

  cpu_bus_model u_bus (.clk_in(ref_clk_in), .run_in(run), .rd_in(bus_rd), .addr_in(bus_addr), .bus_out(cpu_bus_in));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic host);
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    host_access_in <= host;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
    host_access_in <= 1'b0;
  endtask

  // the expected byte is queued before the strobe so the watcher always finds it
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    exp_q.push_back(e);
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk_in)
  begin
    rd_q <= reg_rd_in;
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // read data lands one cycle after the strobe, so look at the following low phase
  always @(negedge ref_clk_in)
  begin
    if (rd_q)
    begin
      exp_v = exp_q.pop_front();
      `CHK("reg_rdata_out", exp_v, reg_rdata_out)
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h6BDE));
    ta = 16'($urandom());
    tb = ta ^ 16'h00FF;
    tp = ta ^ 16'h5A00;
    repeat (8) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    for (int i = 0; i < 16; i++) rd(4'(i), 8'h00);
    wr(dbg_regs_pkg::OFS_FORCE_RST, 8'h01, 1'b0);
    @(negedge ref_clk_in);
    `CHK("chip_reset_out", 1'b0, chip_reset_out)
    wr(dbg_regs_pkg::OFS_FORCE_RST, 8'h01, 1'b1);
    @(negedge ref_clk_in);
    `CHK("chip_reset_out", 1'b1, chip_reset_out)
    @(negedge ref_clk_in);
    `CHK("chip_reset_out", 1'b0, chip_reset_out)
    rd(dbg_regs_pkg::OFS_FORCE_RST, 8'h00);
    wr(dbg_regs_pkg::OFS_CMP_A_HI, ta[15:8], 1'b0);
    wr(dbg_regs_pkg::OFS_CMP_A_LO, ta[7:0], 1'b0);
    wr(dbg_regs_pkg::OFS_CMP_B_HI, tb[15:8], 1'b0);
    wr(dbg_regs_pkg::OFS_CMP_B_LO, tb[7:0], 1'b0);
    rd(dbg_regs_pkg::OFS_CMP_A_HI, ta[15:8]);
    rd(dbg_regs_pkg::OFS_CMP_B_LO, tb[7:0]);
    secure_in <= 1'b1;
    wr(dbg_regs_pkg::OFS_CTRL, 8'h80, 1'b0);
    rd(dbg_regs_pkg::OFS_CTRL, 8'h00);
    secure_in <= 1'b0;
    wr(dbg_regs_pkg::OFS_CTRL, 8'hBF, 1'b0);
    rd(dbg_regs_pkg::OFS_CTRL, 8'hBF);
    // profiling: each disarmed low read parks the current fetch address at the tail
    run <= 1'b1;
    for (int k = 0; k < 16; k++)
    begin
      bus_addr <= ta + 16'(k);
      repeat (3) @(posedge ref_clk_in);
      ev = (k < 8) ? 16'h0000 : ta + 16'(k - 8);
      wr(dbg_regs_pkg::OFS_FIFO_HI, 8'(~k), 1'b0);
      rd(dbg_regs_pkg::OFS_FIFO_HI, ev[15:8]);
      rd(dbg_regs_pkg::OFS_FIFO_HI, ev[15:8]);
      wr(dbg_regs_pkg::OFS_FIFO_LO, 8'(k), 1'b0);
      rd(dbg_regs_pkg::OFS_FIFO_LO, ev[7:0]);
    end
    run <= 1'b0;
    trig_cfg_in.event_only <= 1'b1;
    rd(dbg_regs_pkg::OFS_FIFO_HI, 8'h00);
    trig_cfg_in.event_only <= 1'b0;
    foreach (rows[i])
    begin
      wr(dbg_regs_pkg::OFS_CTRL, {2'b11, 1'(i), rows[i][5], rows[i][3:0]}, 1'b0);
      @(negedge ref_clk_in);
      `CHK("armed_out", 1'b1, armed_out)
      @(posedge ref_clk_in);
      if (i == 0) wr(dbg_regs_pkg::OFS_CMP_B_HI, ~tb[15:8], 1'b0);
      bus_addr <= rows[i][7] ? tb : ta;
      bus_rd <= rows[i][6];
      // qualification on a fetch match must leave the break cycle where it was
      trig_cfg_in.opcode_qualify_select <= (i == 2);
      run <= 1'b1;
      brk_n = 0;
      brk_at = 0;
      for (int k = 0; k < 8; k++)
      begin
        @(negedge ref_clk_in);
        if (cpu_break_out === 1'b1)
        begin
          brk_n++;
          brk_at = k;
          tag_seen = break_tag_out;
        end
      end
      `CHK("break count", int'(rows[i][5] & rows[i][4]), brk_n)
      if (brk_n == 1) `CHK("break_tag_out", 1'(i), tag_seen)
      if (brk_n == 1) `CHK("break cycle", 2, brk_at)
      `CHK("armed_out", ~rows[i][4], armed_out)
      @(posedge ref_clk_in);
      run <= 1'b0;
      wr(dbg_regs_pkg::OFS_CTRL, 8'h80, 1'b0);
      @(negedge ref_clk_in);
      `CHK("armed_out", 1'b0, armed_out)
    end
    rd(dbg_regs_pkg::OFS_CMP_B_HI, tb[15:8]);
    // end trace: twelve fetches overfill the fifo, the trigger cycle itself is not stored
    wr(dbg_regs_pkg::OFS_CTRL, 8'hC0, 1'b0);
    bus_addr <= tp;
    bus_rd <= 1'b1;
    run <= 1'b1;
    repeat (12) @(posedge ref_clk_in);
    bus_addr <= ta;
    repeat (4) @(posedge ref_clk_in);
    run <= 1'b0;
    @(negedge ref_clk_in);
    `CHK("armed_out", 1'b0, armed_out)
    `CHK("fifo_count_out", dbg_regs_pkg::FULL_COUNT, fifo_count_out)
    for (int k = 0; k < 8; k++)
    begin
      rd(dbg_regs_pkg::OFS_FIFO_HI, tp[15:8]);
      rd(dbg_regs_pkg::OFS_FIFO_LO, tp[7:0]);
    end
    // begin trace: nothing is stored before comparator a fires, the break comes with the eighth word
    trig_cfg_in.begin_trace <= 1'b1;
    wr(dbg_regs_pkg::OFS_CTRL, 8'hD0, 1'b0);
    bus_addr <= tp;
    run <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
    bus_addr <= ta;
    brk_n = 0;
    for (int k = 0; k < 16; k++)
    begin
      @(negedge ref_clk_in);
      if (cpu_break_out === 1'b1)
      begin
        brk_n++;
        `CHK("fifo_count_out", dbg_regs_pkg::FULL_COUNT, fifo_count_out)
      end
    end
    `CHK("break count", 1, brk_n)
    `CHK("armed_out", 1'b0, armed_out)
    @(posedge ref_clk_in);
    run <= 1'b0;
    trig_cfg_in.begin_trace <= 1'b0;
    rd(dbg_regs_pkg::OFS_FIFO_HI, ta[15:8]);
    rd(dbg_regs_pkg::OFS_FIFO_LO, ta[7:0]);
    // event-only: comparator b hits store their data byte, the high half stays empty
    trig_cfg_in.event_only <= 1'b1;
    wr(dbg_regs_pkg::OFS_CTRL, 8'hC0, 1'b0);
    bus_addr <= tb;
    run <= 1'b1;
    repeat (16) @(posedge ref_clk_in);
    run <= 1'b0;
    @(negedge ref_clk_in);
    `CHK("armed_out", 1'b0, armed_out)
    `CHK("fifo_count_out", dbg_regs_pkg::FULL_COUNT, fifo_count_out)
    rd(dbg_regs_pkg::OFS_FIFO_LO, tb[7:0]);
    rd(dbg_regs_pkg::OFS_FIFO_LO, tb[7:0]);
    trig_cfg_in.event_only <= 1'b0;
    rd(dbg_regs_pkg::OFS_FIFO_HI, 8'h00);
    // a second reset in mid-run must clear the comparators again
    srst_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    rd(dbg_regs_pkg::OFS_CMP_A_LO, 8'h00);
    rd(dbg_regs_pkg::OFS_CMP_B_LO, 8'h00);
    tally_and_finish();
  end
endmodule

`default_nettype wire

// File: verilog/dbg_regs_pkg.sv
// shared constants and types for the on-chip debug register block
package dbg_regs_pkg;

  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 16;

  // register indices on the debug register port
  localparam logic [3:0] OFS_CMP_A_HI = 4'h0;
  localparam logic [3:0] OFS_CMP_A_LO = 4'h1;
  localparam logic [3:0] OFS_CMP_B_HI = 4'h2;
  localparam logic [3:0] OFS_CMP_B_LO = 4'h3;
  localparam logic [3:0] OFS_FIFO_HI = 4'h4;
  localparam logic [3:0] OFS_FIFO_LO = 4'h5;
  localparam logic [3:0] OFS_CTRL = 4'h6;
  localparam logic [3:0] OFS_FORCE_RST = 4'h9;

  // debug_control field positions
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_ARM_BIT = 6;
  localparam int CTRL_TAG_BIT = 5;
  localparam int CTRL_CPU_BREAK_ENABLE_BIT = 4;
  localparam int CTRL_RWA_BIT = 3;
  localparam int CTRL_CMP_A_DIRECTION_ENABLE_BIT = 2;
  localparam int CTRL_RWB_BIT = 1;
  localparam int CTRL_CMP_B_DIRECTION_ENABLE_BIT = 0;

  // forced_reset_request field position
  localparam int FORCE_CHIP_RESET_BIT = 0;

  localparam logic [7:0] CMP_BYTE_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [3:0] FULL_COUNT = 4'h8;

  // one cpu bus cycle as seen by the comparators
  typedef struct packed {
    logic valid;
    logic read;
    logic opcode_fetch;
    logic [15:0] addr;
    logic [7:0] data;
  } cpu_bus_t;

  // trigger setup held by the neighbouring trigger register
  typedef struct packed {
    logic event_only;
    logic begin_trace;
    logic opcode_qualify_select;
  } trig_cfg_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [FIFO_DEPTH-1:0][FIFO_WIDTH-1:0] fifo;
    logic [3:0] count;
    logic started;
    logic [15:0] last_fetch;
    logic [7:0] rdata;
    logic brk;
    logic brk_tag;
    logic chip_rst;
  } state_t;

endpackage

// File: verilog/onchip_debug_trace_regs.sv
// debug comparators, trace fifo and control registers
`timescale 1ns/1ps
`default_nettype none

module onchip_debug_trace_regs #(
  parameter int DEPTH = dbg_regs_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic host_access_in,
  input wire logic secure_in,
  input wire dbg_regs_pkg::cpu_bus_t cpu_bus_in,
  input wire dbg_regs_pkg::trig_cfg_t trig_cfg_in,
  output logic [7:0] reg_rdata_out,
  output logic armed_out,
  output logic [3:0] fifo_count_out,
  output logic cpu_break_out,
  output logic break_tag_out,
  output logic chip_reset_out
);

  ////////////////////////////////////////////////////////////////////////
  // state

  dbg_regs_pkg::state_t s_reg;
  dbg_regs_pkg::state_t s_next;

  logic armed;
  logic match_a;
  logic match_b;
  logic trigger;
  logic push;
  logic [15:0] push_word;
  logic run_end;
  logic brk_req;
  logic [7:0] ctrl_wr;

  assign armed = s_reg.ctrl[dbg_regs_pkg::CTRL_ARM_BIT];

  ////////////////////////////////////////////////////////////////////////
  // comparators

  always_comb
  begin
    match_a = armed && cpu_bus_in.valid && (cpu_bus_in.addr == s_reg.cmp_a);
    if (s_reg.ctrl[dbg_regs_pkg::CTRL_CMP_A_DIRECTION_ENABLE_BIT])
    begin
      // direction bit one means reads only, zero means writes only
      match_a = match_a && (cpu_bus_in.read == s_reg.ctrl[dbg_regs_pkg::CTRL_RWA_BIT]);
    end
    match_b = armed && cpu_bus_in.valid && (cpu_bus_in.addr == s_reg.cmp_b);
    if (s_reg.ctrl[dbg_regs_pkg::CTRL_CMP_B_DIRECTION_ENABLE_BIT])
    begin
      match_b = match_b && (cpu_bus_in.read == s_reg.ctrl[dbg_regs_pkg::CTRL_RWB_BIT]);
    end
    // qualified triggers wait for an executed fetch at the match address
    if (trig_cfg_in.opcode_qualify_select)
    begin
      trigger = (match_a || match_b) && cpu_bus_in.opcode_fetch;
    end
    else
    begin
      trigger = match_a || match_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // capture sequencing

  always_comb
  begin
    push = 1'b0;
    push_word = 16'h0000;
    run_end = 1'b0;
    brk_req = 1'b0;
    if (armed)
    begin
      if (trig_cfg_in.event_only)
      begin
        // event-only runs store the data byte of each comparator b hit and end when full
        if (match_b)
        begin
          push = 1'b1;
          push_word = {dbg_regs_pkg::READ_ZERO, cpu_bus_in.data};
        end
      end
      else if (trig_cfg_in.begin_trace)
      begin
        if ((s_reg.started || trigger) && cpu_bus_in.valid && cpu_bus_in.opcode_fetch)
        begin
          push = 1'b1;
          push_word = cpu_bus_in.addr;
        end
      end
      else
      begin
        // end trace: circular store until the trigger
        if (trigger)
        begin
          run_end = 1'b1;
          brk_req = 1'b1;
        end
        else if (cpu_bus_in.valid && cpu_bus_in.opcode_fetch)
        begin
          push = 1'b1;
          push_word = cpu_bus_in.addr;
        end
      end
      if ((trig_cfg_in.event_only || trig_cfg_in.begin_trace) && push &&
          (s_reg.count == dbg_regs_pkg::FULL_COUNT - 4'h1))
      begin
        run_end = 1'b1;
        brk_req = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    s_next = s_reg;
    s_next.brk = 1'b0;
    s_next.chip_rst = 1'b0;
    ctrl_wr = reg_wdata_in;

    if (cpu_bus_in.valid && cpu_bus_in.opcode_fetch)
    begin
      s_next.last_fetch = cpu_bus_in.addr;
    end

    if (armed && trigger && trig_cfg_in.begin_trace)
    begin
      s_next.started = 1'b1;
    end

    // shift register: new words enter at the last slot, reads take slot 0
    if (push)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        s_next.fifo[i] = s_reg.fifo[i+1];
      end
      s_next.fifo[DEPTH-1] = push_word;
      if (s_reg.count != dbg_regs_pkg::FULL_COUNT)
      begin
        s_next.count = s_reg.count + 4'h1;
      end
    end

    if (run_end)
    begin
      s_next.ctrl[dbg_regs_pkg::CTRL_ARM_BIT] = 1'b0;
    end

    // break timing comes only from the run sequencing, which qualification reaches through the trigger
    if (brk_req && s_reg.ctrl[dbg_regs_pkg::CTRL_CPU_BREAK_ENABLE_BIT])
    begin
      s_next.brk = 1'b1;
      s_next.brk_tag = s_reg.ctrl[dbg_regs_pkg::CTRL_TAG_BIT];
    end

    //////////////////////////////////////////////////////////////////////
    // register reads: data comes back one cycle after the strobe

    if (reg_rd_in)
    begin
      case (reg_addr_in)
        dbg_regs_pkg::OFS_CMP_A_HI: s_next.rdata = s_reg.cmp_a[15:8];
        dbg_regs_pkg::OFS_CMP_A_LO: s_next.rdata = s_reg.cmp_a[7:0];
        dbg_regs_pkg::OFS_CMP_B_HI: s_next.rdata = s_reg.cmp_b[15:8];
        dbg_regs_pkg::OFS_CMP_B_LO: s_next.rdata = s_reg.cmp_b[7:0];
        dbg_regs_pkg::OFS_FIFO_HI:
        begin
          if (trig_cfg_in.event_only)
          begin
            s_next.rdata = dbg_regs_pkg::READ_ZERO;
          end
          else
          begin
            s_next.rdata = s_reg.fifo[0][15:8];
          end
        end
        dbg_regs_pkg::OFS_FIFO_LO:
        begin
          s_next.rdata = s_reg.fifo[0][7:0];
          // while armed the fifo belongs to the capture logic
          if (!armed)
          begin
            for (int i = 0; i < DEPTH - 1; i++)
            begin
              s_next.fifo[i] = s_reg.fifo[i+1];
            end
            s_next.fifo[DEPTH-1] = s_reg.last_fetch;
          end
        end
        dbg_regs_pkg::OFS_CTRL: s_next.rdata = s_reg.ctrl;
        dbg_regs_pkg::OFS_FORCE_RST: s_next.rdata = dbg_regs_pkg::READ_ZERO;
        default: s_next.rdata = dbg_regs_pkg::READ_ZERO;
      endcase
    end

    //////////////////////////////////////////////////////////////////////
    // register writes

    if (reg_wr_in)
    begin
      case (reg_addr_in)
        dbg_regs_pkg::OFS_CMP_A_HI:
        begin
          if (!armed)
          begin
            s_next.cmp_a[15:8] = reg_wdata_in;
          end
        end
        dbg_regs_pkg::OFS_CMP_A_LO:
        begin
          if (!armed)
          begin
            s_next.cmp_a[7:0] = reg_wdata_in;
          end
        end
        dbg_regs_pkg::OFS_CMP_B_HI:
        begin
          if (!armed)
          begin
            s_next.cmp_b[15:8] = reg_wdata_in;
          end
        end
        dbg_regs_pkg::OFS_CMP_B_LO:
        begin
          if (!armed)
          begin
            s_next.cmp_b[7:0] = reg_wdata_in;
          end
        end
        dbg_regs_pkg::OFS_CTRL:
        begin
          // a secured part may clear the enable but never raise it
          if (secure_in && !s_reg.ctrl[dbg_regs_pkg::CTRL_ENABLE_BIT])
          begin
            ctrl_wr[dbg_regs_pkg::CTRL_ENABLE_BIT] = 1'b0;
          end
          if (!ctrl_wr[dbg_regs_pkg::CTRL_ENABLE_BIT])
          begin
            ctrl_wr[dbg_regs_pkg::CTRL_ARM_BIT] = 1'b0;
          end
          s_next.ctrl = ctrl_wr;
          if (ctrl_wr[dbg_regs_pkg::CTRL_ARM_BIT] && !armed)
          begin
            // a fresh run starts with an empty count
            s_next.count = 4'h0;
            s_next.started = 1'b0;
          end
        end
        dbg_regs_pkg::OFS_FORCE_RST:
        begin
          if (host_access_in && reg_wdata_in[dbg_regs_pkg::FORCE_CHIP_RESET_BIT])
          begin
            s_next.chip_rst = 1'b1;
          end
        end
        // fifo bytes and unmapped indices ignore writes
        default: s_next.rdata = s_next.rdata;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      s_reg <= '0;
      s_reg.cmp_a <= {dbg_regs_pkg::CMP_BYTE_RESET, dbg_regs_pkg::CMP_BYTE_RESET};
      s_reg.cmp_b <= {dbg_regs_pkg::CMP_BYTE_RESET, dbg_regs_pkg::CMP_BYTE_RESET};
      s_reg.ctrl <= dbg_regs_pkg::CTRL_RESET;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata_out = s_reg.rdata;
  assign armed_out = armed;
  assign fifo_count_out = s_reg.count;
  assign cpu_break_out = s_reg.brk;
  assign break_tag_out = s_reg.brk_tag;
  assign chip_reset_out = s_reg.chip_rst;

  ////////////////////////////////////////////////////////////////////////
  // checks

  user_force_rst_a: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    reg_wr_in && !host_access_in && reg_addr_in == dbg_regs_pkg::OFS_FORCE_RST
    |=> !chip_reset_out)
    else $error("user write reached forced reset");

  force_rst_read_a: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    reg_rd_in && reg_addr_in == dbg_regs_pkg::OFS_FORCE_RST |=> reg_rdata_out == 8'h00)
    else $error("forced reset register read nonzero");

  host_force_rst_a: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    reg_wr_in && host_access_in && reg_addr_in == dbg_regs_pkg::OFS_FORCE_RST &&
    reg_wdata_in[0] |=> chip_reset_out ##1 !chip_reset_out)
    else $error("host forced reset not one pulse");

  cmp_reset_a: assert property (
    @(posedge ref_clk_in)
    srst_in |=> s_reg.cmp_a == 16'h0000 && s_reg.cmp_b == 16'h0000)
    else $error("comparators not cleared by reset");

  cmp_lock_a: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    armed && reg_wr_in && reg_addr_in <= dbg_regs_pkg::OFS_CMP_B_LO
    |=> $stable(s_reg.cmp_a) && $stable(s_reg.cmp_b))
    else $error("comparator written while armed");

  fifo_advance_a: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    !armed && reg_rd_in && reg_addr_in == dbg_regs_pkg::OFS_FIFO_LO
    |=> s_reg.fifo[0] == $past(s_reg.fifo[1]) && s_reg.fifo[7] == $past(s_reg.last_fetch))
    else $error("low byte read did not advance and sample");

  hi_read_still_a: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    !armed && reg_rd_in && reg_addr_in == dbg_regs_pkg::OFS_FIFO_HI |=> $stable(s_reg.fifo))
    else $error("high byte read moved the fifo");

  secure_en_a: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    secure_in && !s_reg.ctrl[7] |=> !s_reg.ctrl[7])
    else $error("enable set while secured");

  break_gate_a: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    cpu_break_out |-> $past(s_reg.ctrl[4]) && !armed_out)
    else $error("break without enable or run still armed");

endmodule

`default_nettype wire
